// ---- design/rcs_pkg.sv ----
package rcs_pkg;
  localparam logic [3:0] CTRL_OFS = 4'he;
  localparam logic [3:0] STAT_OFS = 4'hf;
  localparam int HALT_BIT = 7;
  localparam int RS_HI_BIT = 4;
  localparam int RS_LO_BIT = 3;
  localparam int ROUTE_BIT = 2;
  localparam int ALARM2_IRQ_ENABLE_BIT = 1;
  localparam int ALARM1_IRQ_ENABLE_BIT = 0;
  localparam int OSF_BIT = 7;
  localparam int A2F_BIT = 1;
  localparam int A1F_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'h9f;
  localparam logic [7:0] CTRL_RST = 8'h18;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam logic [1:0] RATE_1HZ = 2'h0;
  localparam logic [1:0] RATE_4K = 2'h1;
  localparam logic [1:0] RATE_8K = 2'h2;
  localparam logic [1:0] RATE_32K = 2'h3;
  localparam int DIV_W = 15;
  localparam int DIV_1HZ_BIT = 14;
  localparam int DIV_4K_BIT = 2;
  localparam int DIV_8K_BIT = 1;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_PTR = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} rcs_state_t;
endpackage

// ---- design/rcs_rtc_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// - Control bit 7 halts the oscillator when 1; resets to 0.
// - Rate bits pick 1 Hz, 4.096 kHz, 8.192 kHz or 32.768 kHz.
// - Both rate bits reset to 1, fastest square wave.
// - Routing 1: alarm 1 drives output A, alarm 2 drives output B.
// - Routing 0: output B carries square wave; routing resets to 0.
// - Alarm 2 enable gates alarm 2 onto A or B by routing; resets 0.
// - Alarm 1 enable gates alarm 1 onto A always; resets 0.
// - Output A low while alarm 1 flag and enable set, or alarm 2 routed.
// - Output B low while routing 1, alarm 2 flag and enable set.
// - Oscillator-stopped flag sets on power-up, halt or oscillator failure.
// - Oscillator-stopped flag holds until written 0; writing 1 does nothing.
// - Alarm 2 flag sets on match; write 0 clears, 1 keeps.
// - Alarm 1 flag sets on match; write 0 clears, 1 keeps.
// - Slave only, working at 100 kHz and 400 kHz clock rates.
// - Data falling while clock high is START, begins a transfer.
// - Data rising while clock high is STOP, ends a transfer.
// - Data changes only while clock low; one clock pulse per bit.
// - Receiver holds data low across the acknowledge high phase.
// - Master not-acknowledge ends a read; device releases data line.
// - Slave address is 1101000 plus direction bit, 1 for read.
// - Register pointer advances after every data byte, read or write.
// - Alarm matches are taken on the once-per-second tick.
module rcs_rtc_ctrl
  import rcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic osc_in,
  input wire logic osc_fail,
  input wire logic sec_tick,
  input wire logic alarm1_match,
  input wire logic alarm2_match,
  output logic oscillator_run,
  output logic [3:0] reg_ptr,
  input wire logic [7:0] ext_rd_data,
  output logic ext_wr_en,
  output logic [7:0] ext_wr_data,
  output logic irq_out_a_n,
  output logic irq_out_a_oe,
  output logic square_wave_or_irq_b_n,
  output logic square_wave_or_irq_b_oe
);
  logic [1:0] scl_s_q, sda_s_q, osc_s_q;
  logic scl_d1_q, sda_d1_q, osc_d1_q;
  rcs_state_t state_q;
  logic [3:0] bitcnt_q, ptr_q;
  logic [7:0] shift_q, ctrl_q;
  logic [1:0] idx_q;
  logic rw_q, sda_oe_q;
  logic osf_q, a2f_q, a1f_q;
  logic [DIV_W-1:0] div_q;
  logic irq_a_q, sqb_q;

  function automatic logic [7:0] reg_read(input logic [3:0] p, input logic [7:0] c,
                                          input logic [7:0] s, input logic [7:0] e);
    if (p == CTRL_OFS)
      reg_read = c;
    else if (p == STAT_OFS)
      reg_read = s;
    else
      reg_read = e;
  endfunction

  // Plenty of samples per bit: a 400 kHz high phase spans over 20 clocks
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      osc_s_q <= 2'h0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      osc_d1_q <= 1'b0;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      osc_s_q <= {osc_s_q[0], osc_in};
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
      osc_d1_q <= osc_s_q[1];
    end
  end

  wire scl_now = scl_s_q[1];
  wire sda_now = sda_s_q[1];
  wire scl_rise = scl_now & ~scl_d1_q;
  wire scl_fall = ~scl_now & scl_d1_q;
  wire start_det = scl_now & scl_d1_q & sda_d1_q & ~sda_now;
  wire stop_det = scl_now & scl_d1_q & ~sda_d1_q & sda_now;
  wire byte_done = (state_q == ST_RX) & scl_fall & (bitcnt_q == BYTE_BITS);
  wire addr_hit = (shift_q[7:1] == SLAVE_ADDR);
  wire wr_pulse = byte_done & (idx_q == IDX_DATA);
  wire rd_done = (state_q == ST_MACK) & scl_rise;
  wire [7:0] stat_rd = {osf_q, 5'h00, a2f_q, a1f_q};
  wire [7:0] rd_byte = reg_read(ptr_q, ctrl_q, stat_rd, ext_rd_data);
  wire ctrl_wr = wr_pulse & (ptr_q == CTRL_OFS);
  wire stat_wr = wr_pulse & (ptr_q == STAT_OFS);
  wire route = ctrl_q[ROUTE_BIT];
  wire [1:0] rate = {ctrl_q[RS_HI_BIT], ctrl_q[RS_LO_BIT]};

  // Byte engine; START and STOP take effect from any state
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      idx_q <= IDX_ADDR;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= ST_RX;
      bitcnt_q <= 4'h0;
      idx_q <= IDX_ADDR;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          bitcnt_q <= 4'h0;
        ST_RX:
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_now};
            bitcnt_q <= bitcnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            if (idx_q == IDX_ADDR && !addr_hit)
              state_q <= ST_IDLE;
            else
            begin
              state_q <= ST_ACK;
              sda_oe_q <= 1'b1;
              if (idx_q == IDX_ADDR)
                rw_q <= shift_q[0];
              if (idx_q != IDX_DATA)
                idx_q <= idx_q + 2'h1;
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            bitcnt_q <= 4'h0;
            if (rw_q)
            begin
              state_q <= ST_TX;
              shift_q <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end
            else
            begin
              state_q <= ST_RX;
              sda_oe_q <= 1'b0;
            end
          end
        ST_TX:
          if (scl_fall)
          begin
            if (bitcnt_q == LAST_BIT)
            begin
              state_q <= ST_MACK;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= ~shift_q[6];
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
        ST_MACK:
          if (scl_rise && sda_now)
            state_q <= ST_IDLE;
          else if (scl_fall)
          begin
            state_q <= ST_TX;
            bitcnt_q <= 4'h0;
            shift_q <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
          end
      endcase
    end
  end

  // Pointer wraps from the status register back to zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      ptr_q <= 4'h0;
    else if (byte_done && idx_q == IDX_PTR)
      ptr_q <= shift_q[3:0];
    else if (wr_pulse || rd_done)
      ptr_q <= ptr_q + 4'h1;
  end

  wire osc_stop = ctrl_q[HALT_BIT] | osc_fail;
  wire a1_set = sec_tick & alarm1_match;
  wire a2_set = sec_tick & alarm2_match;

  // Hardware set wins over a software clear landing in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ctrl_q <= CTRL_RST;
      osf_q <= 1'b1;
      a2f_q <= 1'b0;
      a1f_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl_q <= shift_q & CTRL_MASK;
      osf_q <= (osf_q & ~(stat_wr & ~shift_q[OSF_BIT])) | osc_stop;
      a2f_q <= (a2f_q & ~(stat_wr & ~shift_q[A2F_BIT])) | a2_set;
      a1f_q <= (a1f_q & ~(stat_wr & ~shift_q[A1F_BIT])) | a1_set;
    end
  end

  // Divider follows the oscillator only while it runs
  wire osc_rise = osc_s_q[1] & ~osc_d1_q;
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      div_q <= '0;
    else if (osc_rise && !ctrl_q[HALT_BIT])
      div_q <= div_q + 1'b1;
  end

  logic sq_wave;
  always_comb
  begin
    unique case (rate)
      RATE_1HZ: sq_wave = div_q[DIV_1HZ_BIT];
      RATE_4K: sq_wave = div_q[DIV_4K_BIT];
      RATE_8K: sq_wave = div_q[DIV_8K_BIT];
      RATE_32K: sq_wave = osc_d1_q & ~ctrl_q[HALT_BIT];
    endcase
  end

  wire a1_act = a1f_q & ctrl_q[ALARM1_IRQ_ENABLE_BIT];
  wire a2_act = a2f_q & ctrl_q[ALARM2_IRQ_ENABLE_BIT];
  wire irq_a_act = a1_act | (~route & a2_act);
  wire irq_b_act = route & a2_act;

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irq_a_q <= 1'b0;
      sqb_q <= 1'b1;
    end
    else
    begin
      irq_a_q <= irq_a_act;
      sqb_q <= route ? ~irq_b_act : sq_wave;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign oscillator_run = ~ctrl_q[HALT_BIT];
  assign reg_ptr = ptr_q;
  assign ext_wr_en = wr_pulse & (ptr_q != CTRL_OFS) & (ptr_q != STAT_OFS);
  assign ext_wr_data = shift_q;
  assign irq_out_a_n = ~irq_a_q;
  assign irq_out_a_oe = irq_a_q;
  assign square_wave_or_irq_b_n = sqb_q;
  assign square_wave_or_irq_b_oe = ~sqb_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_addr_ok;
    byte_done && idx_q == IDX_ADDR && addr_hit;
  endsequence
  sequence s_ack_held;
    (state_q == ST_ACK && sda_oe_q) [*1];
  endsequence

  irq_a_out_a: assert property (irq_a_act |=> !irq_out_a_n && irq_out_a_oe)
    else $error("output A not low for active alarm");
  irq_b_out_a: assert property (route && a2_act |=> !square_wave_or_irq_b_n)
    else $error("output B not low for alarm 2");
  sqw_route_a: assert property (!route |=> square_wave_or_irq_b_n == $past(sq_wave))
    else $error("output B not carrying square wave");
  osf_halt_a: assert property (ctrl_q[HALT_BIT] |=> osf_q)
    else $error("stop flag not set while halted");
  osf_hold_a: assert property (osf_q && !stat_wr |=> osf_q)
    else $error("stop flag dropped without a write");
  alarm_set_a: assert property (sec_tick && alarm1_match |=> a1f_q)
    else $error("alarm 1 flag missed a match");
  a2_keep_a: assert property (stat_wr && shift_q[A2F_BIT] && !a2_set && !a2f_q |=> !a2f_q)
    else $error("alarm 2 flag set by a write of one");
  addr_ack_a: assert property (s_addr_ok |=> s_ack_held)
    else $error("address byte not acknowledged");
  ptr_step_a: assert property (wr_pulse |=> ptr_q == $past(ptr_q) + 4'h1)
    else $error("pointer did not advance");
  nack_free_a: assert property (rd_done && sda_now && !stop_det |=> !sda_oe && state_q == ST_IDLE)
    else $error("data line held after not-acknowledge");
  start_rx_a: assert property (start_det && !stop_det |=> state_q == ST_RX && !sda_oe)
    else $error("START not detected");
  reserved_a: assert property (ctrl_q[6:5] == 2'h0 && stat_rd[6:2] == 5'h00)
    else $error("reserved bits not zero");
endmodule

// ---- tb/rcs_i2c_master.sv ----
`timescale 1ns/1ps
module rcs_i2c_master
(
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam time QTR = 80ns;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Called only from an idle bus or with clock low, so it also does repeated start
  task automatic start();
    #QTR sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
  endtask
  task automatic stop();
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask
  task automatic put_bit(input logic b);
    #QTR sda_low = ~b;
    #QTR scl = 1'b1;
    #(2*QTR) scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #QTR sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR b = sda;
    #QTR scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i]);
    get_bit(ack);
  endtask
  // A high acknowledge on the last byte ends the read
  task automatic recv_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(last);
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import rcs_pkg::*;
;
  logic ref_clk, reset_n, sec_tick, a1m, a2m, osc_fail, sda_o, sda_oe, osc_run, ext_wr_en;
  logic irq_a_n, irq_a_oe, sq_n, sq_oe;
  logic [3:0] reg_ptr;
  logic [2:0] osc_div;
  logic [7:0] ext_wr_data, last_wr, c, s;
  wire scl, m_low, sda;
  int n_mismatch, n_compared;
  // Open-drain line with pull-up
  assign sda = ~(m_low | sda_oe);
  rcs_i2c_master m_u (.scl(scl), .sda_low(m_low), .sda(sda));
  rcs_rtc_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .osc_in(osc_div[2]), .osc_fail(osc_fail),
    .sec_tick(sec_tick), .alarm1_match(a1m), .alarm2_match(a2m), .oscillator_run(osc_run),
    .reg_ptr(reg_ptr), .ext_rd_data({4'hc, reg_ptr}), .ext_wr_en(ext_wr_en),
    .ext_wr_data(ext_wr_data), .irq_out_a_n(irq_a_n), .irq_out_a_oe(irq_a_oe),
    .square_wave_or_irq_b_n(sq_n), .square_wave_or_irq_b_oe(sq_oe));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    osc_div <= osc_div + 3'h1;
    if (ext_wr_en)
      last_wr <= ext_wr_data;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bus edges fall on falling clock edges so the synchroniser never races a pin change
  task automatic open_ptr(input logic [7:0] ptr);
    logic ack;
    @(negedge ref_clk);
    m_u.start();
    m_u.send_byte({SLAVE_ADDR, 1'b0}, ack);
    check("addr ack", {7'h0, ack}, 8'h00);
    m_u.send_byte(ptr, ack);
  endtask
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
    logic ack;
    open_ptr(ptr);
    m_u.send_byte(d, ack);
    check("data ack", {7'h0, ack}, 8'h00);
    m_u.stop();
    repeat (8) @(posedge ref_clk);
  endtask
  // Reads control then status, leaning on the pointer stepping
  task automatic rd_cs();
    logic ack;
    open_ptr({4'h0, CTRL_OFS});
    @(negedge ref_clk);
    m_u.start();
    m_u.send_byte({SLAVE_ADDR, 1'b1}, ack);
    m_u.recv_byte(c, 1'b0);
    m_u.recv_byte(s, 1'b1);
    check("released", {7'h0, sda_oe}, 8'h00);
    m_u.stop();
  endtask
  task automatic t_reset();
    rd_cs();
    check("ctrl rst", c, 8'h18);
    check("stat rst", s, 8'h80);
    check("irq a", {7'h0, irq_a_n}, 8'h01);
    check("sda out", {7'h0, sda_o}, 8'h00);
  endtask
  task automatic t_rates();
    int cnt;
    int exp_t[4] = '{0, 20, 40, 160};
    logic prev;
    for (int r = 0; r < 4; r++)
    begin
      wr_reg({4'h0, CTRL_OFS}, {3'h0, 2'(r), 3'h0});
      cnt = 0;
      prev = sq_n;
      repeat (640)
      begin
        @(posedge ref_clk);
        cnt += int'(sq_n != prev);
        prev = sq_n;
      end
      check("rate", 8'(cnt >= exp_t[r] - 1 && cnt <= exp_t[r] + 1), 8'h01);
    end
  endtask
  task automatic tick(input logic m1, input logic m2, input logic t);
    @(posedge ref_clk);
    a1m <= m1;
    a2m <= m2;
    sec_tick <= t;
    @(posedge ref_clk);
    {a1m, a2m, sec_tick} <= 3'h0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic t_flags();
    wr_reg({4'h0, STAT_OFS}, 8'h00);
    wr_reg({4'h0, STAT_OFS}, 8'hff);
    wr_reg({4'h0, CTRL_OFS}, 8'h07);
    tick(1'b1, 1'b1, 1'b0);
    check("no tick", {6'h0, irq_a_n, sq_n}, 8'h03);
    tick(1'b1, 1'b1, 1'b1);
    check("irqs", {6'h0, irq_a_n, sq_n}, 8'h00);
    check("irq oe", {6'h0, irq_a_oe, sq_oe}, 8'h03);
    rd_cs();
    check("stat", s, 8'h03);
    wr_reg({4'h0, STAT_OFS}, 8'h02);
    check("a1 clr", {6'h0, irq_a_n, sq_n}, 8'h02);
    wr_reg({4'h0, CTRL_OFS}, 8'h02);
    check("a2 on a", {7'h0, irq_a_n}, 8'h00);
    wr_reg({4'h0, STAT_OFS}, 8'h00);
    check("a2 clr", {7'h0, irq_a_n}, 8'h01);
  endtask
  task automatic t_halt();
    wr_reg({4'h0, CTRL_OFS}, 8'hff);
    check("run", {7'h0, osc_run}, 8'h00);
    rd_cs();
    check("ctrl", c, 8'h9f);
    check("stop flag", s & 8'h80, 8'h80);
  endtask
  task automatic t_multi();
    logic ack;
    open_ptr(8'h0d);
    m_u.send_byte(8'h5a, ack);
    m_u.send_byte(8'h04, ack);
    m_u.stop();
    check("ext wr", last_wr, 8'h5a);
    check("ptr", {4'h0, reg_ptr}, 8'h0f);
    rd_cs();
    check("ctrl step", c, 8'h04);
    @(negedge ref_clk);
    m_u.start();
    m_u.send_byte({7'h69, 1'b0}, ack);
    check("wrong addr", {7'h0, ack}, 8'h01);
    m_u.stop();
  endtask
  initial
  begin
    {reset_n, sec_tick, a1m, a2m, osc_fail, osc_div, last_wr} = '0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_rates();
    t_flags();
    t_multi();
    t_halt();
    conclude();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
endmodule
